/* File: sim/prog_mem_model.sv */
// program memory model answering table accesses
`timescale 1ns/1ps
module prog_mem_model
	import opaddr_pkg::*;
(
	input wire logic clk,
	input wire prog_req_t prog_q,
	input wire logic slow,
	output logic prog_ack,
	output logic [23:0] prog_rdata
);
	logic [23:0] mem [logic [23:0]];
	logic [23:0] w;
	int wait_n = 0;
	initial prog_ack = 1'b0;
	initial prog_rdata = 24'h5a5a5a;
	always @(posedge clk) begin
		prog_ack <= 1'b0;
		// idle data toggles so stale reads show
		prog_rdata <= ~prog_rdata;
		if (prog_q.valid && !prog_ack) begin
			if (wait_n < (slow ? 3 : 0)) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				prog_ack <= 1'b1;
				w = mem.exists(prog_q.addr) ? mem[prog_q.addr] :
					{prog_q.addr[7:0] ^ 8'h3c, prog_q.addr[15:0] ^ 16'h9c63};
				for (int i = 0; i < 3; i++) begin
					if (prog_q.lane_we[i]) begin
						w[8*i+:8] = prog_q.wdata[8*i+:8];
					end
				end
				mem[prog_q.addr] = w;
				prog_rdata <= w;
			end
		end
	end
endmodule

/* File: sim/table_access_operand_addressing_tb_top.sv */
// self-checking bench for operand and table access paths
`timescale 1ns/1ps
module table_access_operand_addressing_tb_top
	import opaddr_pkg::*;
;
	logic clk, rst, op_valid, op_is_mul, pc_advance, page_we, tbl_valid;
	logic slow, prog_ack, ea_valid, ea_is_mem, ea_dest_pair, ea_reg_we;
	logic tbl_ready, tbl_done, tbl_cfg_space;
	addr_mode_t op_mode;
	logic [3:0] op_reg, ea_dest_reg;
	logic [15:0] op_reg_val, op_full_addr, op_mod, ea_addr, ea_literal;
	logic [15:0] ea_reg_update, pc_q, tbl_rdata;
	logic [12:0] op_file_addr;
	logic [9:0] op_literal;
	logic [7:0] page_wdata, table_page_reg;
	logic [23:0] prog_rdata;
	tbl_req_t tbl_req;
	prog_req_t prog_q;
	logic [39:0] q_op[$];
	logic [17:0] q_tb[$];
	logic [23:0] shadow [logic [23:0]];
	int errors = 0, total_checks = 0, cycles = 0;

	table_access_operand_addressing i_dut (.clk(clk), .rst(rst),
		.op_valid(op_valid), .op_mode(op_mode), .op_reg(op_reg),
		.op_reg_val(op_reg_val), .op_file_addr(op_file_addr),
		.op_full_addr(op_full_addr), .op_literal(op_literal), .op_mod(op_mod),
		.op_is_mul(op_is_mul), .op_dest_default_working_reg(1'b0), .ea_valid(ea_valid),
		.ea_addr(ea_addr), .ea_is_mem(ea_is_mem), .ea_literal(ea_literal),
		.ea_dest_reg(ea_dest_reg), .ea_dest_pair(ea_dest_pair),
		.ea_reg_update(ea_reg_update), .ea_reg_we(ea_reg_we),
		.pc_advance(pc_advance), .pc_q(pc_q), .page_we(page_we),
		.page_wdata(page_wdata), .table_page_reg(table_page_reg),
		.tbl_valid(tbl_valid), .tbl_req(tbl_req), .tbl_ready(tbl_ready),
		.tbl_done(tbl_done), .tbl_rdata(tbl_rdata),
		.tbl_cfg_space(tbl_cfg_space), .prog_q(prog_q),
		.prog_ack(prog_ack), .prog_rdata(prog_rdata));
	prog_mem_model i_mem (.clk(clk), .prog_q(prog_q), .slow(slow),
		.prog_ack(prog_ack), .prog_rdata(prog_rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(string nm, logic [16:0] e, logic [16:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic opr(addr_mode_t m, logic mul);
		logic [15:0] v;
		logic [3:0] dst;
		op_mode = m;
		op_is_mul = mul;
		op_valid = 1'b1;
		op_reg = 4'($urandom);
		op_reg_val = 16'($urandom);
		op_mod = 16'($urandom);
		op_file_addr = 13'($urandom);
		op_full_addr = 16'($urandom);
		op_literal = 10'($urandom);
		case (m)
			MODE_IND_PRE: v = op_reg_val + op_mod;
			MODE_LIT5: v = {11'h0, op_literal[4:0]};
			MODE_LIT10: v = {6'h0, op_literal};
			MODE_FILE: v = {3'h0, op_file_addr};
			MODE_FULL: v = op_full_addr;
			default: v = op_reg_val;
		endcase
		dst = (m == MODE_FILE && !mul) ? WORKING_REG_ZERO : op_reg;
		q_op.push_back({m, mul, v, op_reg_val + op_mod, dst});
		@(negedge clk);
	endtask

	function automatic logic [23:0] word_at(logic [23:0] a);
		return shadow.exists(a) ? shadow[a] : {a[7:0] ^ 8'h3c, a[15:0] ^ 16'h9c63};
	endfunction

	task automatic tbl(int k, logic wr);
		logic [23:0] a, w;
		logic [15:0] d, off;
		int n = 0;
		d = 16'($urandom);
		off = {15'h1234, k[0]};
		a = {table_page_reg, off};
		w = word_at(a);
		if (wr) begin
			if (!k[1]) w[8*k[2]+:16] = k[2] ? {d[7:0], w[15:8]} : d;
			else if (!(k[2] && k[0])) w[(k[2] ? 16 : 8*k[0])+:8] = d[7:0];
			shadow[a] = w;
			// writes return no data, only the page flag is noted
			q_tb.push_back({1'b0, table_page_reg[7], 16'h0});
		end else if (!k[1]) q_tb.push_back({1'b1, table_page_reg[7],
			k[2] ? {8'h0, w[23:16]} : w[15:0]});
		else q_tb.push_back({1'b1, table_page_reg[7], 8'h0,
			k[2] ? (k[0] ? 8'h0 : w[23:16]) : w[8*k[0]+:8]});
		while (tbl_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		tbl_valid = 1'b1;
		tbl_req = '{wr ? (k[2] ? TBL_WR_HIGH : TBL_WR_LOW) :
			(k[2] ? TBL_RD_HIGH : TBL_RD_LOW), k[1], off, d};
		@(negedge clk);
		tbl_valid = 1'b0;
	endtask

	always @(negedge clk) begin
		logic [39:0] e;
		logic [17:0] t;
		logic lit;
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
		if (ea_valid === 1'b1 && q_op.size() > 0) begin
			e = q_op.pop_front();
			lit = e[39:37] inside {MODE_LIT5, MODE_LIT10};
			if (e[39:37] != MODE_REG_DIRECT)
				chk("ea_value", {1'b0, e[35:20]},
					{1'b0, lit ? ea_literal : ea_addr});
			chk("ea_flags", {14'h0, !lit && e[39:37] != MODE_REG_DIRECT,
				e[39:37] inside {MODE_IND_POST, MODE_IND_PRE}, e[36]},
				{14'h0, ea_is_mem, ea_reg_we, ea_dest_pair});
			chk("ea_dest", {13'h0, e[3:0]}, {13'h0, ea_dest_reg});
			if (ea_reg_we === 1'b1)
				chk("ea_update", {1'b0, e[19:4]}, {1'b0, ea_reg_update});
		end
		if (tbl_done === 1'b1 && q_tb.size() > 0) begin
			t = q_tb.pop_front();
			if (t[17])
				chk("tbl_rdata", t[16:0],
				{tbl_cfg_space, tbl_rdata});
			else
				chk("tbl_cfg", {16'h0, t[16]}, {16'h0, tbl_cfg_space});
		end
	end

	initial begin
		void'($urandom(61));
		{rst, op_valid, op_is_mul, pc_advance, page_we, tbl_valid, slow} = 7'h40;
		{op_reg, op_reg_val, op_full_addr, op_mod, op_file_addr} = '0;
		{op_literal, page_wdata, tbl_req} = '0;
		op_mode = MODE_REG_DIRECT;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk("page_reset", 17'h0, {9'h0, table_page_reg});
		pc_advance = 1'b1;
		repeat (5) @(negedge clk);
		pc_advance = 1'b0;
		chk("pc", 17'h000a, {1'b0, pc_q});
		for (int m = 0; m < 8; m++) opr(addr_mode_t'(m), m == 7);
		opr(MODE_REG_DIRECT, 1'b1);
		op_valid = 1'b0;
		for (int p = 0; p < 2; p++) begin
			slow = p[0];
			page_we = 1'b1;
			page_wdata = {p[0], 7'($urandom)};
			@(negedge clk);
			page_we = 1'b0;
			for (int r = 0; r < 3; r++) begin
				for (int k = 0; k < 8; k++) tbl(k, r == 1);
			end
		end
		repeat (30) @(negedge clk);
		chk("queues", 17'h0, 17'(q_op.size() + q_tb.size()));
		wrap_up();
	end
endmodule

/* File: verilog/opaddr_pkg.sv */
// shared constants and carriers for operand addressing and table access
package opaddr_pkg;
	localparam int DATA_W = 16;
	localparam int PROG_W = 24;
	localparam int PAGE_W = 8;
	localparam int FILE_ADDR_W = 13;
	localparam int DEFAULT_WORKING_REG_IDX_W = 4;
	localparam int LIT5_W = 5;
	localparam int LIT10_W = 10;
	localparam int PAGE_CFG_BIT = 7;
	localparam int BYTE_W = 8;
	localparam logic [3:0] WORKING_REG_ZERO = 4'h0;
	localparam logic [15:0] PC_STEP = 16'h0002;
	localparam logic [7:0] PAGE_RESET = 8'h00;

	typedef enum logic [2:0] {
		MODE_REG_DIRECT = 3'h0,
		MODE_REG_INDIRECT = 3'h1,
		MODE_IND_POST = 3'h2,
		MODE_IND_PRE = 3'h3,
		MODE_LIT5 = 3'h4,
		MODE_LIT10 = 3'h5,
		MODE_FILE = 3'h6,
		MODE_FULL = 3'h7
	} addr_mode_t;

	typedef enum logic [2:0] {
		TBL_NONE = 3'h0,
		TBL_RD_LOW = 3'h1,
		TBL_RD_HIGH = 3'h2,
		TBL_WR_LOW = 3'h3,
		TBL_WR_HIGH = 3'h4
	} tbl_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b11
	} tbl_state_t;

	typedef struct packed {
		tbl_op_t op;
		logic byte_mode;
		logic [15:0] offset;
		logic [15:0] wdata;
	} tbl_req_t;

	typedef struct packed {
		logic valid;
		logic [23:0] addr;
		logic [23:0] wdata;
		logic [2:0] lane_we;
		logic rd;
	} prog_req_t;
endpackage

/* File: verilog/table_access_operand_addressing.sv */
// operand address resolution and program-space table access path
// Function
// - file register ops reach only lowest 8192 bytes via 13-bit field
// - working register zero implied; result to file or it (no selection made here, op_dest_default_working_reg is unused); multiply to pair
// - move instruction may address the whole data space
// - first three-operand source is a working register, register direct
// - second source from register, memory or 5-bit literal; result reg/mem
// - direct, indirect, post-, pre-modified indirect and literal modes
// - low table ops access program low word directly
// - high table ops alone reach the upper program byte
// - program counter steps by two per program word
// - low read word mode copies P<15:0> to D<15:0>
// - low read byte mode picks byte by byte select into low byte
// - high read word mode gives P<23:16>, upper byte zero
// - high read byte mode gives selected byte, phantom byte reads zero
// - table writes store bytes or words mirroring the read modes
// - page register bit 7 selects user or configuration memory
// - only paged table ops reach configuration area
`timescale 1ns/1ps
module table_access_operand_addressing
	import opaddr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	// operand resolution request
	input wire logic op_valid,
	input wire addr_mode_t op_mode,
	input wire logic [3:0] op_reg,
	input wire logic [15:0] op_reg_val,
	input wire logic [12:0] op_file_addr,
	input wire logic [15:0] op_full_addr,
	input wire logic [9:0] op_literal,
	input wire logic [15:0] op_mod,
	input wire logic op_is_mul,
	input wire logic op_dest_default_working_reg,
	output logic ea_valid,
	output logic [15:0] ea_addr,
	output logic ea_is_mem,
	output logic [15:0] ea_literal,
	output logic [3:0] ea_dest_reg,
	output logic ea_dest_pair,
	output logic [15:0] ea_reg_update,
	output logic ea_reg_we,
	// program counter
	input wire logic pc_advance,
	output logic [15:0] pc_q,
	// page register
	input wire logic page_we,
	input wire logic [7:0] page_wdata,
	output logic [7:0] table_page_reg,
	// table request
	input wire logic tbl_valid,
	input wire tbl_req_t tbl_req,
	output logic tbl_ready,
	output logic tbl_done,
	output logic [15:0] tbl_rdata,
	output logic tbl_cfg_space,
	// program memory side
	output prog_req_t prog_q,
	input wire logic prog_ack,
	input wire logic [23:0] prog_rdata
);
	tbl_state_t state_q;
	tbl_op_t op_q;
	logic byte_mode_q;
	logic bsel_q;
	logic [15:0] ind_addr;
	logic [15:0] lit_val;
	logic [23:0] wide_w;
	logic [2:0] lanes;
	logic [15:0] rd_word;

	always_comb begin
		ind_addr = op_reg_val;
		if (op_mode == MODE_IND_PRE) begin
			ind_addr = op_reg_val + op_mod;
		end
	end

	always_comb begin
		lit_val = {11'h000, op_literal[LIT5_W-1:0]};
		if (op_mode == MODE_LIT10) begin
			lit_val = {6'h00, op_literal};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ea_valid <= 1'b0;
			ea_addr <= 16'h0000;
			ea_is_mem <= 1'b0;
			ea_literal <= 16'h0000;
		end else begin
			ea_valid <= op_valid;
			if (op_valid) begin
				ea_literal <= 16'h0000;
				case (op_mode)
				MODE_REG_DIRECT: begin
					ea_addr <= {12'h000, op_reg};
					ea_is_mem <= 1'b0;
				end
				MODE_REG_INDIRECT, MODE_IND_POST, MODE_IND_PRE: begin
					ea_addr <= ind_addr;
					ea_is_mem <= 1'b1;
				end
				MODE_LIT5, MODE_LIT10: begin
					ea_addr <= 16'h0000;
					ea_is_mem <= 1'b0;
					ea_literal <= lit_val;
				end
				MODE_FILE: begin
					ea_addr <= {3'h0, op_file_addr};
					ea_is_mem <= 1'b1;
				end
				MODE_FULL: begin
					ea_addr <= op_full_addr;
					ea_is_mem <= 1'b1;
				end
				default: begin
					ea_addr <= 16'h0000;
					ea_is_mem <= 1'b0;
				end
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ea_dest_reg <= WORKING_REG_ZERO;
			ea_dest_pair <= 1'b0;
		end else if (op_valid) begin
			ea_dest_pair <= op_is_mul;
			if (op_is_mul) begin
				ea_dest_reg <= op_reg;
			end else if (op_mode == MODE_FILE) begin
				ea_dest_reg <= WORKING_REG_ZERO;
			end else begin
				ea_dest_reg <= op_reg;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ea_reg_update <= 16'h0000;
			ea_reg_we <= 1'b0;
		end else begin
			ea_reg_we <= op_valid && (op_mode == MODE_IND_POST ||
				op_mode == MODE_IND_PRE);
			if (op_valid) begin
				ea_reg_update <= op_reg_val + op_mod;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_q <= 16'h0000;
		end else if (pc_advance) begin
			pc_q <= pc_q + PC_STEP;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			table_page_reg <= PAGE_RESET;
		end else if (page_we) begin
			table_page_reg <= page_wdata;
		end
	end

	always_comb begin
		wide_w = {8'h00, tbl_req.wdata};
		lanes = 3'h3;
		if (tbl_req.op == TBL_WR_HIGH) begin
			wide_w = {tbl_req.wdata[7:0], 16'h0000};
			lanes = 3'h4;
			if (tbl_req.byte_mode && tbl_req.offset[0]) begin
				lanes = 3'h0;
			end
		end else if (tbl_req.byte_mode) begin
			wide_w = {8'h00, tbl_req.wdata[7:0], tbl_req.wdata[7:0]};
			lanes = tbl_req.offset[0] ? 3'h2 : 3'h1;
		end
	end

	// table access sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			op_q <= TBL_NONE;
			byte_mode_q <= 1'b0;
			bsel_q <= 1'b0;
			prog_q <= '0;
			tbl_cfg_space <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (tbl_valid && tbl_req.op != TBL_NONE) begin
					state_q <= ST_WAIT;
					op_q <= tbl_req.op;
					byte_mode_q <= tbl_req.byte_mode;
					bsel_q <= tbl_req.offset[0];
					prog_q.valid <= 1'b1;
					prog_q.addr <= {table_page_reg, tbl_req.offset};
					tbl_cfg_space <= table_page_reg[PAGE_CFG_BIT];
					prog_q.rd <= (tbl_req.op == TBL_RD_LOW) ||
						(tbl_req.op == TBL_RD_HIGH);
					prog_q.wdata <= wide_w;
					prog_q.lane_we <= (tbl_req.op == TBL_WR_LOW ||
						tbl_req.op == TBL_WR_HIGH) ? lanes : 3'h0;
				end
			end
			ST_WAIT: begin
				if (prog_ack) begin
					state_q <= ST_DONE;
					prog_q.valid <= 1'b0;
				end
			end
			ST_DONE: begin
				state_q <= ST_IDLE;
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	always_comb begin
		rd_word = prog_rdata[15:0];
		if (op_q == TBL_RD_HIGH) begin
			rd_word = {8'h00, prog_rdata[23:16]};
			if (byte_mode_q && bsel_q) begin
				rd_word = 16'h0000;
			end
		end else if (byte_mode_q) begin
			rd_word = {8'h00, bsel_q ? prog_rdata[15:8] : prog_rdata[7:0]};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tbl_done <= 1'b0;
			tbl_rdata <= 16'h0000;
			tbl_ready <= 1'b0;
		end else begin
			tbl_ready <= (state_q == ST_IDLE) &&
				!(tbl_valid && tbl_req.op != TBL_NONE);
			tbl_done <= (state_q == ST_WAIT) && prog_ack;
			if (state_q == ST_WAIT && prog_ack && prog_q.rd) begin
				tbl_rdata <= rd_word;
			end
		end
	end

	a_pc_step: assert property (@(posedge clk) disable iff (rst)
		pc_advance |=> pc_q == $past(pc_q) + PC_STEP)
		else $error("pc did not step by two");
	// address formed from page and offset
	a_addr_concat: assert property (@(posedge clk) disable iff (rst)
		(state_q == ST_IDLE && tbl_valid && tbl_req.op != TBL_NONE) |=>
		prog_q.addr == {$past(table_page_reg), $past(tbl_req.offset)})
		else $error("table address mismatch");
	a_cfg_flag: assert property (@(posedge clk) disable iff (rst)
		prog_q.valid |-> tbl_cfg_space == prog_q.addr[23])
		else $error("config space flag wrong");
	a_high_phantom: assert property (@(posedge clk) disable iff (rst)
		(tbl_done && op_q == TBL_RD_HIGH) |-> tbl_rdata[15:8] == 8'h00)
		else $error("phantom byte not zero");
	a_file_near: assert property (@(posedge clk) disable iff (rst)
		(op_valid && op_mode == MODE_FILE) |=> ea_addr[15:13] == 3'h0)
		else $error("file address beyond near space");
	// file ops default to working register zero
	a_file_default_working_reg: assert property (@(posedge clk) disable iff (rst)
		(op_valid && op_mode == MODE_FILE && !op_is_mul) |=>
		ea_dest_reg == WORKING_REG_ZERO)
		else $error("file op destination not register zero");
	// pointer update only on modified modes
	a_ptr_update: assert property (@(posedge clk) disable iff (rst)
		ea_reg_we |-> $past(op_mode) inside {MODE_IND_POST, MODE_IND_PRE})
		else $error("spurious pointer update");
	// low byte read upper byte zero
	a_low_byte: assert property (@(posedge clk) disable iff (rst)
		(tbl_done && op_q == TBL_RD_LOW && byte_mode_q) |->
		tbl_rdata[15:8] == 8'h00)
		else $error("byte read upper byte not zero");
	a_read_no_we: assert property (@(posedge clk) disable iff (rst)
		prog_q.rd |-> prog_q.lane_we == 3'h0)
		else $error("read drives write lanes");
	c_rd_high: cover property (@(posedge clk) tbl_done && op_q == TBL_RD_HIGH);
	c_rd_low_byte: cover property (@(posedge clk)
		tbl_done && op_q == TBL_RD_LOW && byte_mode_q);
	c_write: cover property (@(posedge clk) tbl_done && op_q == TBL_WR_HIGH);
	c_cfg: cover property (@(posedge clk) prog_q.valid && tbl_cfg_space);
endmodule
